/* File: core/asro_pkg.sv */
// Shared constants and types of the serial result output path.
package asro_pkg;

  // ----------------------------------------------------------------
  // Frame timing, counted in serial clock rising edges
  // ----------------------------------------------------------------
  localparam int          ASRO_RESULT_WIDTH  = 14;
  localparam int          ASRO_COUNT_WIDTH   = 5;
  localparam int          ASRO_SYNC_STAGES   = 2;
  localparam logic [4:0]  ASRO_FRAME_EDGES   = 5'h10;
  localparam logic [4:0]  ASRO_FIRST_DATA    = 5'h03;
  localparam logic [4:0]  ASRO_PAST_FRAME    = 5'h11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic drive;
    logic data;
  } asro_sdo_type;

  localparam asro_sdo_type ASRO_SDO_RESET = '{drive: 1'b0, data: 1'b0};

  typedef enum logic [1:0] {
    ASRO_ST_IDLE  = 2'b01,
    ASRO_ST_FRAME = 2'b10
  } asro_state_type;

endpackage

/* File: core/asro_edge_sync.sv */
// Two-stage pin synchroniser with rising edge detection for a group of inputs.
module asro_edge_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_rise
);
  import asro_pkg::*;

  // ----------------------------------------------------------------
  // Synchroniser and edge detect
  // ----------------------------------------------------------------
  // The first stage feeds only the second; the edge detector looks at
  // the second and third stages so a metastable sample never reaches logic.
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;
  logic [WIDTH-1:0] rise_reg;
  logic [WIDTH-1:0] rise_next;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        rise_next[g] = sync_reg[g] & ~last_reg[g];
      end
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          last_reg[g] <= 1'b0;
          rise_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_pin[g];
          sync_reg[g] <= meta_reg[g];
          last_reg[g] <= sync_reg[g];
          rise_reg[g] <= rise_next[g];
        end
      end
    end
  endgenerate

  assign o_rise = rise_reg;

endmodule

/* File: core/asro_serial_out.sv */
// Serial result output path: frames results onto the three-wire data pin.
//
// Functional notes
// (RULE_01) Data pin undriven after power-up.
// (RULE_02) Stay undriven until new conversion starts.
// (RULE_03) Two's complement result from third clock edge.
// (RULE_04) Undriven whenever no result bit presented.
// (RULE_05) Bit valid by next clock rising edge.
// (RULE_06) Each frame spans sixteen serial clocks.
// (RULE_07) Ignore start edges until sixteen clocks follow.
// (RULE_08) Controller gives sixteen clocks between starts.
// (RULE_09) Update on rising edges, MSB first.
// (RULE_10) Controller samples falling edges, right justified.
// (RULE_11) Accepted start restarts the bit counter.
module asro_serial_out #(
  parameter int RESULT_WIDTH = asro_pkg::ASRO_RESULT_WIDTH
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_resetn,
  input  wire logic                      i_sck,
  input  wire logic                      i_conversion_start_strobe,
  input  wire logic [RESULT_WIDTH-1:0]   i_result,
  output asro_pkg::asro_sdo_type         o_sdo,
  output logic                           o_busy
);
  import asro_pkg::*;

  localparam logic [4:0] LAST_DATA = 5'(int'(ASRO_FIRST_DATA) + RESULT_WIDTH - 1);
  localparam logic [4:0] ONE       = 5'h01;

  // The data window is decoded both by the sequencer and by its checks.
  function automatic logic in_window(input logic [4:0] pos);
    return (pos >= ASRO_FIRST_DATA) && (pos <= LAST_DATA);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] rise;
  logic       sck_rise;
  logic       strobe_rise;

  // A pin edge reaches the sequencer three clocks late, so the controller
  // must hold each serial clock phase for at least two system clocks.
  asro_edge_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    ({i_conversion_start_strobe, i_sck}),
    .o_rise   (rise)
  );

  assign sck_rise    = rise[0];
  assign strobe_rise = rise[1];

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  asro_state_type            state_reg;
  asro_state_type            state_next;
  logic [4:0]                cnt_reg;
  logic [4:0]                cnt_next;
  logic [4:0]                cnt_inc;
  logic [RESULT_WIDTH-1:0]   shift_reg;
  logic [RESULT_WIDTH-1:0]   shift_next;
  asro_sdo_type              sdo_reg;
  asro_sdo_type              sdo_next;
  logic                      busy_reg;
  logic                      busy_next;
  logic                      accept;
  logic                      in_data;

  always_comb begin
    accept     = 1'b0;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    sdo_next   = sdo_reg;
    cnt_inc    = cnt_reg + ONE;
    in_data    = in_window(cnt_inc);
    unique case (state_reg)
      ASRO_ST_IDLE: begin
        accept = strobe_rise;
      end
      ASRO_ST_FRAME: begin
        accept = 1'b0; // RULE_07
      end
    endcase
    if (accept) begin
      state_next = ASRO_ST_FRAME;
      cnt_next   = 5'h00; // RULE_11
      shift_next = i_result; // RULE_03
      sdo_next   = ASRO_SDO_RESET; // RULE_02
    end else if (sck_rise) begin
      // Saturate past the frame so stray clocks never reopen the data window.
      if (cnt_reg < ASRO_PAST_FRAME) begin
        cnt_next = cnt_inc;
      end
      if (state_reg == ASRO_ST_FRAME && cnt_inc == ASRO_FRAME_EDGES) begin
        state_next = ASRO_ST_IDLE; // RULE_06
      end
      if (in_data && cnt_reg < ASRO_PAST_FRAME) begin
        sdo_next.drive = 1'b1; // RULE_03
        sdo_next.data  = shift_reg[RESULT_WIDTH-1]; // RULE_09
        shift_next     = {shift_reg[RESULT_WIDTH-2:0], 1'b0}; // RULE_09
      end else begin
        sdo_next = ASRO_SDO_RESET; // RULE_04
      end
    end
    busy_next = (state_next == ASRO_ST_FRAME);
  end

  // The last bit of a frame is held until the next clock edge or start,
  // since the controller samples it on the falling edge after it appears.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ASRO_ST_IDLE;
      cnt_reg   <= ASRO_PAST_FRAME;
      shift_reg <= '0;
      sdo_reg   <= ASRO_SDO_RESET; // RULE_01
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      sdo_reg   <= sdo_next; // RULE_05
      busy_reg  <= busy_next;
    end
  end

  assign o_sdo  = sdo_reg;
  assign o_busy = busy_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic                    started_reg;
  logic                    started_next;
  logic [RESULT_WIDTH-1:0] word_reg;
  logic [RESULT_WIDTH-1:0] word_next;

  always_comb begin
    started_next = started_reg | accept;
    word_next    = accept ? i_result : word_reg;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      started_reg <= 1'b0;
      word_reg    <= '0;
    end else begin
      started_reg <= started_next;
      word_reg    <= word_next;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  AST_QUIET_AFTER_RESET: assert property ( // RULE_01
    !started_reg |-> !o_sdo.drive
  ) else $error("Data pin driven before any conversion start.");

  AST_START_RELEASES: assert property ( // RULE_02
    accept |=> !o_sdo.drive ##0 (cnt_reg == 5'h00)
  ) else $error("Data pin not released at conversion start.");

  AST_MSB_ON_THIRD: assert property ( // RULE_03
    (state_reg == ASRO_ST_FRAME && sck_rise && !accept && cnt_reg == 5'h02)
      |=> o_sdo.drive && (o_sdo.data == word_reg[RESULT_WIDTH-1])
  ) else $error("Result MSB not presented at the third clock edge.");

  AST_NO_EARLY_BIT: assert property ( // RULE_03
    (state_reg == ASRO_ST_FRAME && sck_rise && !accept && cnt_reg < 5'h02) |=> !o_sdo.drive
  ) else $error("Data pin driven before the third clock edge.");

  AST_START_TAKES_RESULT: assert property ( // RULE_03
    accept |=> (shift_reg == $past(i_result))
  ) else $error("Result not captured at conversion start.");

  AST_DRIVE_WINDOW: assert property ( // RULE_04
    o_sdo.drive |-> in_window(cnt_reg)
  ) else $error("Data pin driven outside the result bit window.");

  AST_UNDRIVEN_LOW: assert property ( // RULE_04
    !o_sdo.drive |-> !o_sdo.data
  ) else $error("Data value shown while the pin is undriven.");

  AST_LAST_BIT_RELEASE: assert property ( // RULE_04
    (sck_rise && !accept && cnt_reg == LAST_DATA) |=> !o_sdo.drive
  ) else $error("Data pin not released after the last result bit.");

  AST_STABLE_BETWEEN: assert property ( // RULE_05
    (!sck_rise && !accept) |=> $stable(o_sdo)
  ) else $error("Data pin changed without a clock edge or start.");

  AST_FRAME_LENGTH: assert property ( // RULE_06
    (state_reg == ASRO_ST_FRAME && sck_rise && cnt_reg == 5'h0f)
      |=> (state_reg == ASRO_ST_IDLE) && !o_busy
  ) else $error("Frame did not close after sixteen clock edges.");

  AST_IGNORE_START: assert property ( // RULE_07
    (state_reg == ASRO_ST_FRAME && strobe_rise && !sck_rise) |=> $stable(cnt_reg)
  ) else $error("Start edge inside a frame was not ignored.");

  AST_MSB_FIRST: assert property ( // RULE_09
    (sck_rise && !accept && o_sdo.drive && cnt_reg < LAST_DATA)
      |=> o_sdo.drive && (o_sdo.data == $past(shift_reg[RESULT_WIDTH-1]))
  ) else $error("Result bits not shifted out in order.");

  AST_COUNT_RESTART: assert property ( // RULE_11
    (strobe_rise && state_reg == ASRO_ST_IDLE) |=> (cnt_reg == 5'h00) && o_busy
  ) else $error("Accepted start did not restart the bit counter.");

  COV_FULL_FRAME: cover property (
    accept ##1 (state_reg == ASRO_ST_FRAME) [*8] ##[1:400] (state_reg == ASRO_ST_IDLE)
  );
  COV_IGNORED_START: cover property (state_reg == ASRO_ST_FRAME && strobe_rise);
  COV_LAST_BIT: cover property (sck_rise && cnt_reg == LAST_DATA);
  COV_START_SATURATED: cover property (accept && cnt_reg == ASRO_PAST_FRAME);
  COV_IDLE_CLOCK: cover property (state_reg == ASRO_ST_IDLE && sck_rise && !started_reg);

endmodule

/* File: testbench/asro_ctrl_model.sv */
// Controller model that frames transfers and captures the serial data pin.
module asro_ctrl_model (
  input  wire logic            i_clock,
  input  wire asro_pkg::asro_sdo_type i_sdo,
  output logic                 o_sck,
  output logic                 o_strobe,
  output logic [35:0]          o_word,
  output logic                 o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import asro_pkg::*;

  initial begin
    o_sck = 1'b0;
    o_strobe = 1'b0;
    o_word = '0;
    o_valid = 1'b0;
  end

  // Each phase lasts six system clocks, so the pin settles well before sampling.
  task automatic half();
    repeat (6) @(negedge i_clock);
  endtask

  // A glitch index above 1 raises the start strobe again inside the frame.
  task automatic run_frame(input int glitch);
    o_strobe = 1'b1;
    half();
    for (int k = 0; k < 18; k++) begin
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
      o_word = {o_word[34:18], i_sdo.drive, o_word[16:0], i_sdo.data};
      repeat (3) @(negedge i_clock);
      if (k == 1) o_strobe = 1'b0;
      if (glitch > 1 && k == glitch) o_strobe = 1'b1;
      repeat (3) @(negedge i_clock);
    end
    // The serial clock stands still between frames.
    o_strobe = 1'b0;
    o_valid = 1'b1;
    @(negedge i_clock);
    o_valid = 1'b0;
  endtask

  // Serial clocks with no start must leave the data pin undriven.
  task automatic idle_clocks(input int n);
    for (int k = 0; k < n; k++) begin
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
      half();
    end
  endtask
endmodule

/* File: testbench/asro_serial_out_tb_top.sv */
// Self-checking bench for the serial result output path.
module asro_serial_out_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asro_pkg::*;

  localparam int W = ASRO_RESULT_WIDTH;
  logic         i_clock;
  logic         i_resetn;
  logic [W-1:0] i_result;
  asro_sdo_type o_sdo;
  logic         o_busy;
  logic         sck;
  logic         strobe;
  logic         valid;
  logic [35:0]  word;
  logic [35:0]  exp_q[$];
  logic [31:0]  lfsr = 32'h6db5de46;
  int           fail_count = 0;
  int           num_checks = 0;
  int           cycles = 0;

  asro_serial_out #(.RESULT_WIDTH(W)) i_dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_sck(sck),
    .i_conversion_start_strobe(strobe), .i_result(i_result),
    .o_sdo(o_sdo), .o_busy(o_busy));

  asro_ctrl_model i_model (
    .i_clock(i_clock), .i_sdo(o_sdo), .o_sck(sck),
    .o_strobe(strobe), .o_word(word), .o_valid(valid));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The result input changes mid-frame, so a late capture would show.
  task automatic frame(input logic [W-1:0] res, input int glitch);
    i_result = res;
    exp_q.push_back({18'(((1 << W) - 1) << 2), 18'({res, 2'b00})});
    fork
      i_model.run_frame(glitch);
      begin
        repeat (40) @(negedge i_clock);
        check({35'h0, o_busy}, 36'h1);
        lfsr = lfsr_next(lfsr);
        i_result = lfsr[W-1:0];
      end
    join
    @(negedge i_clock);
    check({35'h0, o_busy}, 36'h0);
    $display("frame done result=%h glitch=%0d", res, glitch);
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    forever begin
      @(posedge valid);
      check(word, exp_q.pop_front());
    end
  end

  initial begin
    i_resetn = 1'b0;
    i_result = '0;
    repeat (2) @(negedge i_clock);
    check({34'h0, o_sdo}, 36'h0);
    i_resetn = 1'b1;
    repeat (10) @(negedge i_clock);
    check({34'h0, o_sdo}, 36'h0);
    i_model.idle_clocks(4);
    check({34'h0, o_sdo}, 36'h0);
    $display("reset and idle clock test done");
    frame(14'h2000, -1);
    frame(14'h1fff, -1);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      frame(lfsr[W-1:0], (i == 1) ? 8 : -1);
    end
    repeat (4) @(negedge i_clock);
    stop_test();
  end
endmodule
